// ===== pkg/sacc_pkg.sv
/*
  sacc_pkg: constants and carrier types for the converter conversion-control block.
  assumes a single 10 MHz clock; all times are converted to cycles here.
*/
package sacc_pkg;

  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int RESULT_WIDTH = 16;
  localparam int LANE_WIDTH = 8;
  localparam int BIT_INDEX_WIDTH = 4;
  localparam logic [BIT_INDEX_WIDTH-1:0] MSB_INDEX = 4'h f;
  localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 16'h0000;
  localparam logic [RESULT_WIDTH-1:0] TRIAL_MSB = 16'h8000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 10_000_000;
  localparam int CLOCK_PERIOD_NS = 1_000_000_000 / CLOCK_HZ;
  // internal bit-decision step; sixteen steps must fit inside one conversion
  localparam int BIT_STEP_NS = 400;
  localparam int BIT_STEP_CYCLES = (BIT_STEP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int STEP_COUNT_WIDTH = 4;
  // latch update to busy release spacing
  localparam int LATCH_TO_BUSY_NS = 200;
  localparam int LATCH_TO_BUSY_CYCLES =
    (LATCH_TO_BUSY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SACC_IDLE,
    SACC_CONVERT,
    SACC_RELEASE
  } sacc_phase_t;

  typedef struct packed {
    logic [LANE_WIDTH-1:0] upper_data_lanes;
    logic [LANE_WIDTH-1:0] lower_data_lanes;
  } sacc_bus_t;

  typedef struct packed {
    logic chip_select_n;
    logic read_convert;
    logic half_swap;
  } sacc_ctl_t;

endpackage

// ===== logic/sacc_word_buffer.sv
/*
  sacc_word_buffer: two-entry valid/ready buffer for finished result words.
  assumes source and sink on the same clock; synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none

module sacc_word_buffer #(
  parameter int WIDTH = 16
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  import sacc_pkg::*;

  typedef struct packed {
    logic [1:0][WIDTH-1:0] slot;
    logic [1:0] count;
  } sacc_buf_state_t;

  sacc_buf_state_t state_reg;
  sacc_buf_state_t state_next;
  logic push;
  logic pop;

  assign o_ready = (state_reg.count != 2'd2);
  assign o_valid = (state_reg.count != 2'd0);
  assign o_data = state_reg.slot[0];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_comb
  begin
    state_next = state_reg;
    if (pop)
    begin
      state_next.slot[0] = state_reg.slot[1];
    end
    if (push)
    begin
      if (state_reg.count == 2'd0 || (state_reg.count == 2'd1 && pop))
        state_next.slot[0] = i_data;
      else if (pop)
        state_next.slot[0] = i_data;
      else
        state_next.slot[1] = i_data;
    end
    if (push && pop && state_reg.count == 2'd2)
      state_next.slot[1] = i_data;
    state_next.count = 2'(state_reg.count + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

endmodule // sacc_word_buffer

`default_nettype wire

// ===== logic/sacc_conversion_control.sv
/*
  sacc_conversion_control: conversion sequencing, busy status and three-state
  result bus of a 16-bit successive-approximation converter.
  assumes host pins are asynchronous (synchronised here) and an external
  comparator answers each bit trial; the pin pads resolve the enables.
*/
`timescale 1ns/100ps
`default_nettype none

module sacc_conversion_control (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire sacc_pkg::sacc_ctl_t i_ctl,
  input wire logic i_compare_high,
  output logic o_sample_hold,
  output sacc_pkg::sacc_bus_t o_trial_word,
  output logic o_busy,
  output sacc_pkg::sacc_bus_t o_data,
  output logic [sacc_pkg::RESULT_WIDTH-1:0] o_data_oe,
  output logic o_word_valid,
  input wire logic i_word_ready,
  output logic [sacc_pkg::RESULT_WIDTH-1:0] o_word
);
  import sacc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    sacc_ctl_t sync1;
    sacc_ctl_t sync2;
    logic start_level;
    logic enable_level;
    sacc_phase_t phase;
    logic [RESULT_WIDTH-1:0] trial;
    logic [RESULT_WIDTH-1:0] latch;
    logic [BIT_INDEX_WIDTH-1:0] bit_index;
    logic [STEP_COUNT_WIDTH-1:0] step_count;
    logic busy;
    logic drive;
    sacc_bus_t data;
    logic push;
  } sacc_state_t;

  sacc_state_t state_reg;
  sacc_state_t state_next;
  logic start_request;
  logic enable_request;
  logic combined_start;
  logic buffer_ready;
  logic step_tick;

  function automatic sacc_bus_t sacc_lanes(input logic [RESULT_WIDTH-1:0] word,
                                           input logic swap);
    sacc_bus_t lanes;
    if (swap)
      lanes = {word[LANE_WIDTH-1:0], word[RESULT_WIDTH-1:LANE_WIDTH]};
    else
      lanes = word;
    return lanes;
  endfunction

  // ----------------------------------------------------------------
  // pin decode
  // ----------------------------------------------------------------
  // the two inputs are ORed, so one low level serves both start paths
  assign combined_start = !state_reg.sync2.chip_select_n && !state_reg.sync2.read_convert;
  // falling of the OR output: covers both read/convert and chip select edges
  assign start_request = combined_start && !state_reg.start_level;
  assign enable_request = !state_reg.sync2.chip_select_n && state_reg.sync2.read_convert;
  assign step_tick = (state_reg.step_count == STEP_COUNT_WIDTH'(BIT_STEP_CYCLES - 1));

  always_comb
  begin
    state_next = state_reg;
    state_next.sync1 = i_ctl;
    state_next.sync2 = state_reg.sync1;
    state_next.start_level = combined_start;
    state_next.enable_level = enable_request;
    state_next.push = 1'b0;
    // rising read/convert under chip select, or chip select falling under read
    state_next.drive = enable_request;
    state_next.data = sacc_lanes(state_reg.latch, state_reg.sync2.half_swap);
    unique case (state_reg.phase)
      SACC_IDLE:
      begin
        if (start_request)
        begin
          state_next.phase = SACC_CONVERT;
          state_next.busy = 1'b0;
          state_next.trial = TRIAL_MSB;
          state_next.bit_index = MSB_INDEX;
          state_next.step_count = '0;
        end
      end
      SACC_CONVERT:
      begin
        // further start edges fall through untouched here
        state_next.step_count = STEP_COUNT_WIDTH'(state_reg.step_count + 1'b1);
        if (step_tick)
        begin
          state_next.step_count = '0;
          // keep or drop the bit under trial, then try the next lower one
          state_next.trial[state_reg.bit_index] = i_compare_high;
          if (state_reg.bit_index == '0)
          begin
            state_next.trial = {state_reg.trial[RESULT_WIDTH-1:1], i_compare_high};
            state_next.latch = {state_reg.trial[RESULT_WIDTH-1:1], i_compare_high};
            state_next.push = buffer_ready;
            state_next.phase = SACC_RELEASE;
          end
          else
          begin
            state_next.trial[state_reg.bit_index - 1'b1] = 1'b1;
            state_next.bit_index = state_reg.bit_index - 1'b1;
          end
        end
      end
      SACC_RELEASE:
      begin
        // busy waits one latch-settle interval so the data already stands
        state_next.step_count = STEP_COUNT_WIDTH'(state_reg.step_count + 1'b1);
        if (state_reg.step_count == STEP_COUNT_WIDTH'(LATCH_TO_BUSY_CYCLES - 1))
        begin
          state_next.busy = 1'b1;
          state_next.phase = SACC_IDLE;
          // a start level still present now is not an edge: host keeps one high
          state_next.step_count = '0;
        end
      end
      default:
      begin
        state_next.phase = SACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      state_reg <= '0;
      state_reg.sync1 <= 3'b110;
      state_reg.sync2 <= 3'b110;
      state_reg.busy <= 1'b1;
      state_reg.start_level <= 1'b0;
      state_reg.phase <= SACC_IDLE;
    end
    else
      state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // result stream
  // ----------------------------------------------------------------
  // a word is dropped only if the sink stalls past two conversions
  sacc_word_buffer #(
    .WIDTH(RESULT_WIDTH)
  ) u_buffer (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_valid(state_reg.push),
    .o_ready(buffer_ready),
    .i_data(state_reg.latch),
    .o_valid(o_word_valid),
    .i_ready(i_word_ready),
    .o_data(o_word)
  );

  assign o_sample_hold = (state_reg.phase == SACC_CONVERT);
  assign o_trial_word = state_reg.trial;
  assign o_busy = state_reg.busy;
  assign o_data = state_reg.data;
  assign o_data_oe = {RESULT_WIDTH{state_reg.drive}};

  // ----------------------------------------------------------------
  // checks: conversion sequence
  // ----------------------------------------------------------------
  // busy-low stretch: one step per result bit, then the latch-settle gap
  localparam int BUSY_LOW_CYCLES = RESULT_WIDTH * BIT_STEP_CYCLES + LATCH_TO_BUSY_CYCLES;
  localparam int BUSY_HOLD = BUSY_LOW_CYCLES - 1;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  start_busy_low_a: assert property (start_request && state_reg.phase == SACC_IDLE
    |=> !o_busy)
    else $error("busy did not fall at conversion start");

  sample_hold_a: assert property (start_request && state_reg.phase == SACC_IDLE
    |=> o_sample_hold)
    else $error("hold not entered at conversion start");

  trial_clear_a: assert property (start_request && state_reg.phase == SACC_IDLE
    |=> o_trial_word == TRIAL_MSB)
    else $error("trial register not cleared at start");

  idle_busy_a: assert property (state_reg.phase == SACC_IDLE |-> o_busy)
    else $error("busy low while idle");

  converting_busy_a: assert property (state_reg.phase != SACC_IDLE |-> !o_busy)
    else $error("busy high during conversion");

  busy_length_a: assert property ($fell(o_busy)
    |-> ##BUSY_HOLD !o_busy ##1 o_busy)
    else $error("busy low stretch has wrong length");

  no_restart_a: assert property (state_reg.phase == SACC_CONVERT && start_request
    |=> state_reg.phase != SACC_IDLE
    && BIT_INDEX_WIDTH'($past(state_reg.bit_index) - state_reg.bit_index) <= 4'h1)
    else $error("conversion restarted");

  msb_first_a: assert property (step_tick && state_reg.phase == SACC_CONVERT
    && state_reg.bit_index != '0
    |=> state_reg.bit_index == $past(state_reg.bit_index) - 1'b1)
    else $error("bit order wrong");

  bit_keep_a: assert property (step_tick && state_reg.phase == SACC_CONVERT
    |=> state_reg.trial[$past(state_reg.bit_index)] == $past(i_compare_high))
    else $error("bit decision not taken from the comparator");

  trial_bit_set_a: assert property (state_reg.phase == SACC_CONVERT
    |-> state_reg.trial[state_reg.bit_index])
    else $error("bit under trial is not set");

  lower_bits_clear_a: assert property (state_reg.phase == SACC_CONVERT
    |-> (state_reg.trial & ((16'h0001 << state_reg.bit_index) - 16'h0001)) == 16'h0000)
    else $error("bits below the trial bit are not clear");

  step_bound_a: assert property (state_reg.phase != SACC_IDLE
    |-> state_reg.step_count < STEP_COUNT_WIDTH'(BIT_STEP_CYCLES))
    else $error("decision step counter overran");

  latch_copy_a: assert property (state_next.phase == SACC_RELEASE
    && state_reg.phase == SACC_CONVERT |=> state_reg.latch == o_trial_word)
    else $error("latch differs from trial word");

  push_result_a: assert property (state_next.phase == SACC_RELEASE
    && state_reg.phase == SACC_CONVERT && buffer_ready |=> state_reg.push)
    else $error("finished word not handed to the buffer");

  busy_after_latch_a: assert property (state_reg.phase == SACC_CONVERT
    && state_next.phase == SACC_RELEASE |=> !o_busy [*2])
    else $error("busy rose with latch update");

  hold_release_a: assert property ($rose(o_busy) |-> !o_sample_hold)
    else $error("still holding after busy rose");

  latch_before_busy_a: assert property ($rose(o_busy) |-> $stable(state_reg.latch))
    else $error("latch changed at busy rising");

  result_valid_a: assert property ($rose(o_busy) && !$past(state_reg.sync2.half_swap)
    |-> o_data == state_reg.latch)
    else $error("result not on the output at busy rising");

  // ----------------------------------------------------------------
  // checks: result bus
  // ----------------------------------------------------------------
  float_bus_a: assert property ($past(state_reg.sync2.chip_select_n
    || !state_reg.sync2.read_convert) |-> o_data_oe == '0)
    else $error("bus driven while deselected or converting");

  drive_on_a: assert property (enable_request |=> o_data_oe == '1)
    else $error("bus not driven for a read");

  normal_lanes_a: assert property (!state_reg.sync2.half_swap
    |=> o_data == $past(state_reg.latch))
    else $error("lanes not in word order");

  swap_lanes_a: assert property (state_reg.sync2.half_swap
    |=> o_data.upper_data_lanes == $past(state_reg.latch[LANE_WIDTH-1:0])
    && o_data.lower_data_lanes == $past(state_reg.latch[RESULT_WIDTH-1:LANE_WIDTH]))
    else $error("lanes not swapped");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  start_cv: cover property (start_request && state_reg.phase == SACC_IDLE);
  done_cv: cover property ($rose(o_busy));
  read_cv: cover property ($rose(o_data_oe[0]));
  swap_cv: cover property (o_data_oe[0] && state_reg.sync2.half_swap);
  restart_cv: cover property (state_reg.phase == SACC_CONVERT && start_request);

endmodule // sacc_conversion_control

`default_nettype wire

// ===== tb/sacc_host_model.sv
/*
  sacc_host_model: comparator side of the bit trials, answering from a target code.
  assumes the target code stays fixed for the whole conversion.
*/
`timescale 1ns/100ps
`default_nettype none

module sacc_host_model (
  input wire sacc_pkg::sacc_bus_t i_trial_word,
  input wire logic [sacc_pkg::RESULT_WIDTH-1:0] i_target,
  output logic o_compare_high
);
  import sacc_pkg::*;
  // ----------------------------------------------------------------
  // comparator
  // ----------------------------------------------------------------
  // keeping a bit only while the trial does not overshoot lands on the target
  assign o_compare_high = (i_trial_word <= i_target);
endmodule // sacc_host_model

`default_nettype wire

// ===== tb/sacc_conversion_control_tb_top.sv
/*
  sacc_conversion_control_tb_top: self-checking bench for the conversion control.
  assumes sacc_host_model answers every bit trial from the target code.
*/
`timescale 1ns/100ps
`default_nettype none

module sacc_conversion_control_tb_top;
  import sacc_pkg::*;
  localparam int BUSY_LOW = 16 * BIT_STEP_CYCLES + LATCH_TO_BUSY_CYCLES;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  sacc_ctl_t ctl = '{chip_select_n: 1'b1, read_convert: 1'b1, half_swap: 1'b0};
  logic cmp_high;
  logic sample_hold;
  sacc_bus_t trial_word;
  logic busy;
  sacc_bus_t data;
  logic [RESULT_WIDTH-1:0] data_oe;
  logic word_valid;
  logic word_ready = 1'b0;
  logic [RESULT_WIDTH-1:0] word;
  logic [RESULT_WIDTH-1:0] target = 16'h0000;
  int errors = 0;
  int n_compared = 0;
  int run = 0;
  int last_run = 0;

  always #50 i_clock = ~i_clock;

  sacc_conversion_control dut (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_ctl(ctl),
    .i_compare_high(cmp_high),
    .o_sample_hold(sample_hold),
    .o_trial_word(trial_word),
    .o_busy(busy),
    .o_data(data),
    .o_data_oe(data_oe),
    .o_word_valid(word_valid),
    .i_word_ready(word_ready),
    .o_word(word)
  );

  sacc_host_model host (
    .i_trial_word(trial_word),
    .i_target(target),
    .o_compare_high(cmp_high)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // length of the last busy-low stretch, in clock cycles
  always @(negedge i_clock)
  begin
    if (busy === 1'b0)
      run <= run + 1;
    else if (run != 0)
    begin
      last_run <= run;
      run <= 0;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic run_conv(input logic by_cs, input logic glitch);
    int k;
    k = 0;
    if (by_cs)
    begin
      ctl.read_convert = 1'b0;
      tick(1);
      ctl.chip_select_n = 1'b0;
    end
    else
    begin
      ctl.chip_select_n = 1'b0;
      tick(1);
      ctl.read_convert = 1'b0;
    end
    tick(1);
    while (busy !== 1'b0 && k < 10)
    begin
      tick(1);
      k++;
    end
    check("busy_start", {15'h0000, busy}, 16'h0000);
    check("sample_hold", {15'h0000, sample_hold}, 16'h0001);
    check("trial_clear", trial_word, TRIAL_MSB);
    check("oe_float_rc_low", data_oe, 16'h0000);
    tick(8);
    // rc back high early, long past the minimum low width
    ctl.read_convert = 1'b1;
    if (by_cs)
      ctl.chip_select_n = 1'b1;
    if (glitch)
    begin
      tick(4);
      ctl.read_convert = 1'b0;
      tick(4);
      ctl.read_convert = 1'b1;
    end
    // rc stays high when busy rises, so no restart
    k = 0;
    while (busy !== 1'b1 && k < 200)
    begin
      tick(1);
      k++;
    end
    tick(1);
    check("busy_low_len", last_run[15:0], BUSY_LOW[15:0]);
  endtask

  task automatic read_word(input logic [15:0] exp);
    ctl.chip_select_n = 1'b0;
    tick(4);
    check("oe_on", data_oe, 16'hffff);
    check("data_word", data, exp);
    ctl.half_swap = 1'b1;
    tick(3);
    check("data_swap", data, {exp[7:0], exp[15:8]});
    ctl.half_swap = 1'b0;
    ctl.chip_select_n = 1'b1;
    tick(4);
    check("oe_off_cs_high", data_oe, 16'h0000);
    // acquisition gap before any next start
    tick(20);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic sc_rc_start;
    target = 16'h1234;
    run_conv(1'b0, 1'b0);
    read_word(16'h1234);
  endtask

  task automatic sc_cs_start;
    target = 16'hffff;
    run_conv(1'b1, 1'b0);
    read_word(16'hffff);
  endtask

  // buffer already holds two words, so this one is refused
  task automatic sc_restart_ignored;
    target = 16'h0000;
    run_conv(1'b0, 1'b1);
    read_word(16'h0000);
    check("buf_full_head", word, 16'h1234);
  endtask

  task automatic sc_drain;
    check("buf_valid", {15'h0000, word_valid}, 16'h0001);
    word_ready = 1'b1;
    tick(1);
    check("buf_second", word, 16'hffff);
    tick(1);
    check("buf_empty", {15'h0000, word_valid}, 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    tick(7);
    check("reset_busy", {15'h0000, busy}, 16'h0001);
    check("reset_oe", data_oe, 16'h0000);
    tick(1);
    i_nrst = 1'b1;
    tick(2);
    sc_rc_start();
    sc_cs_start();
    sc_restart_ignored();
    sc_drain();
    tally_and_finish();
  end

  initial
  begin
    tick(3000);
    errors++;
    tally_and_finish();
  end
endmodule // sacc_conversion_control_tb_top

`default_nettype wire
